// >>> logic/fsc_map.svh
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH
// Register indices; byte address on the bus is four times the index
`define FSC_IDX_MODE 8'h84
`define FSC_IDX_PCTL 8'h87
`define FSC_IDX_BAUD 8'h94
`define FSC_IDX_ADDRESS_MATCH_0 8'h95
`define FSC_IDX_IFS 8'hA4
`define FSC_IDX_ADDRESS_MATCH_1 8'hA5
`define FSC_IDX_ADDRESS_MATCH_2 8'hB5
`define FSC_IDX_BACKOFF_COUNTDOWN 8'hC4
`define FSC_IDX_ADDRESS_MATCH_3 8'hC5
`define FSC_IDX_ADDRESS_DONT_CARE_0 8'hD5
`define FSC_IDX_ADDRESS_DONT_CARE_1 8'hE5
`define FSC_IDX_SLOT 8'hF5
`define FSC_IDX_SLOTTM 8'h0B
// Mode register fields
`define FSC_MODE_PROTO 0
`define FSC_MODE_PRE_LO 1
`define FSC_MODE_PRE_HI 2
`define FSC_MODE_CRC 3
`define FSC_MODE_ALEN 4
`define FSC_MODE_SEL_LO 5
`define FSC_MODE_SEL_HI 6
`define FSC_MODE_XTX 7
// Power and channel control fields
`define FSC_PCTL_FILL 2
`define FSC_PCTL_XRX 3
`define FSC_PCTL_B2B 4
`define FSC_PCTL_MASK 8'h1C
// Slot and jam fields
`define FSC_SLOT_DCR 6
`define FSC_SLOT_DCJ 7
// Reset values
`define FSC_RST_BYTE 8'h00
// Timing counts
`define FSC_PRESCALE_MAX 3'h7
`define FSC_PRE_8 7'h08
`define FSC_PRE_32 7'h20
`define FSC_PRE_64 7'h40
`define FSC_SLOT_ZERO_WAIT 8'h40
`define FSC_SLOT_TOP 6'h3F
`endif

// >>> logic/fsc_pkg.sv
package fsc_pkg;
	// Operating modes in the order of their two select bits
	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_RAW_TX,
		MODE_RAW_RX,
		MODE_ALT_BACKOFF
	} fsc_mode_type;
endpackage

// >>> logic/fsc_core.sv
`timescale 1ns/1ps
`include "fsc_map.svh"
// Operation
// - 8-bit: any match; 16-bit: pair match
// - Mask ones make match 0/1 bits don't-care
// - All-ones address always recognised
// - Bit rate is clock over 8 times (divisor+1)
// - Divisor reloads at zero; reads show live count
// - Backoff counts slots, readable, writes ignored
// - Protocol bit picks SDLC/NRZI or CSMA/CD/Manchester
// - Preamble codes give 0, 8, 32, 64 bits
// - CSMA/CD preamble holds two-one start marker
// - CRC bit picks 32-bit or 16-bit CRC
// - Mode bits: normal, raw tx, raw rx, alternate
// - Raw receive stores all bytes including CRC
// - Raw transmit loops internally, no framing added
// - Alternate backoff waits for interframe space end
// - External clocks replace generator for tx/rx
// - Interframe count halved, run twice, zero gives 256
// - Interframe read: count high, pass flag low
// - Slot number sets priority; zero waits all slots
// - Deterministic mode: slot backoff, no carrier retrigger
// - Jam bit picks DC or AC jam
// - Idle flag fill only in SDLC
// - Back-to-back SDLC keeps receiver on at end flag
module fsc_core (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// External bit clocks and line pins
	input wire logic ext_tx_clk_i,
	input wire logic ext_rx_clk_i,
	input wire logic rx_pin_i,
	output logic tx_pin_o,
	// Framing engine side
	input wire logic tx_data_i,
	input wire logic [15:0] rx_addr_i,
	input wire logic rx_addr_valid_i,
	input wire logic collision_i,
	input wire logic [7:0] backoff_seed_i,
	input wire logic ifs_start_i,
	input wire logic carrier_i,
	input wire logic end_flag_i,
	output logic rx_data_o,
	output logic addr_hit_o,
	output logic tx_bit_o,
	output logic rx_bit_o,
	output logic slot_tick_o,
	output logic ifs_busy_o,
	output logic backoff_busy_o,
	output logic rx_stop_o,
	output logic rx_end_o,
	// Decoded configuration
	output logic sdlc_o,
	output logic crc32_o,
	output logic [6:0] preamble_bits_o,
	output logic start_marker_ones_o,
	output logic raw_tx_o,
	output logic raw_rx_o,
	output logic alt_backoff_o,
	output logic det_res_o,
	output logic dc_jam_o,
	output logic idle_fill_o
);
	typedef struct packed {
		logic ack;
		logic [7:0] dat;
		logic [7:0] mode;
		logic [7:0] pctl;
		logic [7:0] baud_rld;
		logic [7:0] baud_cnt;
		logic [2:0] pre;
		logic [7:0] address_match_0;
		logic [7:0] address_match_1;
		logic [7:0] address_match_2;
		logic [7:0] address_match_3;
		logic [7:0] msk0;
		logic [7:0] msk1;
		logic [7:0] slot;
		logic [7:0] slot_len;
		logic [7:0] slot_cnt;
		logic [6:0] ifs_rld;
		logic [6:0] ifs_cnt;
		logic ifs_first;
		logic ifs_run;
		logic [7:0] backoff_countdown;
		logic bk_run;
		logic bk_pend;
		logic [2:0] txs;
		logic tx_lvl;
		logic [2:0] rxs;
		logic rx_lvl;
		logic [2:0] dps;
		logic dp_lvl;
		logic hit;
		logic tx_bit;
		logic rx_bit;
		logic slot_tick;
		logic tx_pin;
		logic rx_data;
		logic rx_stop;
		logic rx_end;
		logic [6:0] pre_bits;
		logic marker;
		logic raw_tx;
		logic raw_rx;
		logic alt;
		logic fill;
	} fsc_state_type;

	fsc_state_type s_ff;
	fsc_state_type nxt_s;

	// Masked compare; a one in the mask drops that bit from the test
	function automatic logic fsc_match(input logic [15:0] a, input logic [15:0] r,
		input logic [15:0] m);
		fsc_match = ((a ^ r) & ~m) == 16'h0000;
	endfunction

	// Three-stage synchroniser level: changes only when stages two and three agree
	function automatic logic fsc_level(input logic [2:0] sy, input logic lvl);
		fsc_level = (sy[1] == sy[2]) ? sy[2] : lvl;
	endfunction

	fsc_pkg::fsc_mode_type mode_sel;
	logic [7:0] idx;
	logic req;
	logic wr;
	logic gen_tick;
	logic tx_tick;
	logic rx_tick;
	logic slot_evt;
	logic ifs_done;
	logic [7:0] bk_load;
	logic alt_bk;
	logic deterministic_resolution;
	logic sdlc;
	logic [6:0] ifs_dec;
	logic [7:0] rd_val;
	logic tx_lvl_n;
	logic rx_lvl_n;
	logic dp_lvl_n;
	logic hit8;
	logic hit16;

	assign mode_sel = fsc_pkg::fsc_mode_type'(s_ff.mode[`FSC_MODE_SEL_HI:`FSC_MODE_SEL_LO]);
	assign idx = wb_adr_i[9:2];
	assign req = wb_cyc_i && wb_stb_i && !s_ff.ack;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign deterministic_resolution = s_ff.slot[`FSC_SLOT_DCR];
	assign sdlc = s_ff.mode[`FSC_MODE_PROTO];
	assign alt_bk = (mode_sel == fsc_pkg::MODE_ALT_BACKOFF);

	////////////////////////////////////////////////////////////////////////////////
	// Combinational next state
	always_comb begin
		nxt_s = s_ff;
		// Bus answer is one cycle after the request, so ack never stays high twice
		nxt_s.ack = req;
		// Clock pins pass three flops before their edges are trusted
		nxt_s.txs = {s_ff.txs[1:0], ext_tx_clk_i};
		nxt_s.rxs = {s_ff.rxs[1:0], ext_rx_clk_i};
		nxt_s.dps = {s_ff.dps[1:0], rx_pin_i};
		tx_lvl_n = fsc_level(s_ff.txs, s_ff.tx_lvl);
		rx_lvl_n = fsc_level(s_ff.rxs, s_ff.rx_lvl);
		dp_lvl_n = fsc_level(s_ff.dps, s_ff.dp_lvl);
		nxt_s.tx_lvl = tx_lvl_n;
		nxt_s.rx_lvl = rx_lvl_n;
		nxt_s.dp_lvl = dp_lvl_n;

		// Divide by eight, then by divisor+1 with reload at zero
		gen_tick = (s_ff.pre == `FSC_PRESCALE_MAX) && (s_ff.baud_cnt == 8'h00);
		nxt_s.pre = 3'(s_ff.pre + 3'h1);
		if (s_ff.pre == `FSC_PRESCALE_MAX) begin
			nxt_s.baud_cnt = (s_ff.baud_cnt == 8'h00) ? s_ff.baud_rld
				: 8'(s_ff.baud_cnt - 8'h01);
		end
		// Transmit and receive bit clocks may come from the pins instead
		tx_tick = s_ff.mode[`FSC_MODE_XTX] ? (tx_lvl_n && !s_ff.tx_lvl) : gen_tick;
		rx_tick = s_ff.pctl[`FSC_PCTL_XRX] ? (rx_lvl_n && !s_ff.rx_lvl) : gen_tick;
		nxt_s.tx_bit = tx_tick;
		nxt_s.rx_bit = rx_tick;

		// Slot timer: a loaded zero wraps round to 256 bit times
		slot_evt = 1'b0;
		if (tx_tick) begin
			nxt_s.slot_cnt = 8'(s_ff.slot_cnt - 8'h01);
			if (nxt_s.slot_cnt == 8'h00) begin
				slot_evt = 1'b1;
				nxt_s.slot_cnt = s_ff.slot_len;
			end
		end
		nxt_s.slot_tick = slot_evt;

		// Interframe space: the seven-bit count runs down twice
		ifs_done = 1'b0;
		ifs_dec = 7'(s_ff.ifs_cnt - 7'h01);
		if (s_ff.ifs_run && tx_tick) begin
			nxt_s.ifs_cnt = ifs_dec;
			if (ifs_dec == 7'h00) begin
				nxt_s.ifs_cnt = s_ff.ifs_rld;
				nxt_s.ifs_first = 1'b0;
				if (!s_ff.ifs_first) begin
					nxt_s.ifs_run = 1'b0;
					ifs_done = 1'b1;
				end
			end
		end
		// Returning carrier restarts the space, except under slot resolution
		if (ifs_start_i || (carrier_i && s_ff.ifs_run && !deterministic_resolution)) begin
			nxt_s.ifs_run = 1'b1;
			nxt_s.ifs_first = 1'b1;
			nxt_s.ifs_cnt = s_ff.ifs_rld;
		end

		// Backoff load: fixed by slot number, or a random seed
		if (deterministic_resolution) begin
			bk_load = (s_ff.slot[5:0] == 6'h00) ? `FSC_SLOT_ZERO_WAIT
				: {2'b00, 6'(`FSC_SLOT_TOP - s_ff.slot[5:0])};
		end else begin
			bk_load = backoff_seed_i;
		end
		if (s_ff.bk_run && slot_evt) begin
			nxt_s.backoff_countdown = 8'(s_ff.backoff_countdown - 8'h01);
			if (s_ff.backoff_countdown == 8'h01) begin
				nxt_s.bk_run = 1'b0;
			end
		end
		// Alternate mode holds the countdown until the space has run out
		if (s_ff.bk_pend && ifs_done) begin
			nxt_s.bk_pend = 1'b0;
			nxt_s.bk_run = (s_ff.backoff_countdown != 8'h00);
		end
		if (collision_i) begin
			nxt_s.backoff_countdown = bk_load;
			if ((alt_bk || deterministic_resolution) && (s_ff.ifs_run || ifs_start_i)) begin
				nxt_s.bk_pend = 1'b1;
				nxt_s.bk_run = 1'b0;
			end else begin
				nxt_s.bk_pend = 1'b0;
				nxt_s.bk_run = (bk_load != 8'h00);
			end
		end

		// Address recognition, all-ones first
		hit8 = (rx_addr_i[7:0] == 8'hFF)
			|| fsc_match({8'h00, rx_addr_i[7:0]}, {8'h00, s_ff.address_match_0}, {8'h00, s_ff.msk0})
			|| fsc_match({8'h00, rx_addr_i[7:0]}, {8'h00, s_ff.address_match_1}, {8'h00, s_ff.msk1})
			|| (rx_addr_i[7:0] == s_ff.address_match_2) || (rx_addr_i[7:0] == s_ff.address_match_3);
		hit16 = (rx_addr_i == 16'hFFFF)
			|| fsc_match(rx_addr_i, {s_ff.address_match_1, s_ff.address_match_0}, {s_ff.msk1, s_ff.msk0})
			|| (rx_addr_i == {s_ff.address_match_3, s_ff.address_match_2});
		nxt_s.hit = rx_addr_valid_i && (s_ff.mode[`FSC_MODE_ALEN] ? hit16 : hit8);

		// Raw transmit loops the line inside the port, ahead of the pin
		nxt_s.tx_pin = (mode_sel == fsc_pkg::MODE_RAW_TX) ? 1'b1 : tx_data_i;
		nxt_s.rx_data = (mode_sel == fsc_pkg::MODE_RAW_TX) ? tx_data_i : dp_lvl_n;

		// End flag; back-to-back SDLC leaves the receiver running
		nxt_s.rx_end = end_flag_i;
		nxt_s.rx_stop = end_flag_i && !(sdlc && s_ff.pctl[`FSC_PCTL_B2B]);

		// Preamble length from its code
		unique case (s_ff.mode[`FSC_MODE_PRE_HI:`FSC_MODE_PRE_LO])
			2'b00: nxt_s.pre_bits = 7'h00;
			2'b01: nxt_s.pre_bits = `FSC_PRE_8;
			2'b10: nxt_s.pre_bits = `FSC_PRE_32;
			2'b11: nxt_s.pre_bits = `FSC_PRE_64;
		endcase

		// Register writes; the backoff index is read only
		if (wr) begin
			unique case (idx)
				`FSC_IDX_MODE: nxt_s.mode = wb_dat_i[7:0];
				`FSC_IDX_PCTL: nxt_s.pctl = wb_dat_i[7:0] & `FSC_PCTL_MASK;
				`FSC_IDX_BAUD: nxt_s.baud_rld = wb_dat_i[7:0];
				`FSC_IDX_ADDRESS_MATCH_0: nxt_s.address_match_0 = wb_dat_i[7:0];
				`FSC_IDX_ADDRESS_MATCH_1: nxt_s.address_match_1 = wb_dat_i[7:0];
				`FSC_IDX_ADDRESS_MATCH_2: nxt_s.address_match_2 = wb_dat_i[7:0];
				`FSC_IDX_ADDRESS_MATCH_3: nxt_s.address_match_3 = wb_dat_i[7:0];
				`FSC_IDX_ADDRESS_DONT_CARE_0: nxt_s.msk0 = wb_dat_i[7:0];
				`FSC_IDX_ADDRESS_DONT_CARE_1: nxt_s.msk1 = wb_dat_i[7:0];
				`FSC_IDX_SLOT: nxt_s.slot = wb_dat_i[7:0];
				`FSC_IDX_SLOTTM: nxt_s.slot_len = wb_dat_i[7:0];
				`FSC_IDX_IFS: nxt_s.ifs_rld = wb_dat_i[7:1];
				default: nxt_s.dat = nxt_s.dat; // Unmapped and backoff: ignored
			endcase
		end

		// Read mux; timer values may be a tick old under external clocks
		unique case (idx)
			`FSC_IDX_MODE: rd_val = s_ff.mode;
			`FSC_IDX_PCTL: rd_val = s_ff.pctl;
			`FSC_IDX_BAUD: rd_val = s_ff.baud_cnt;
			`FSC_IDX_ADDRESS_MATCH_0: rd_val = s_ff.address_match_0;
			`FSC_IDX_ADDRESS_MATCH_1: rd_val = s_ff.address_match_1;
			`FSC_IDX_ADDRESS_MATCH_2: rd_val = s_ff.address_match_2;
			`FSC_IDX_ADDRESS_MATCH_3: rd_val = s_ff.address_match_3;
			`FSC_IDX_ADDRESS_DONT_CARE_0: rd_val = s_ff.msk0;
			`FSC_IDX_ADDRESS_DONT_CARE_1: rd_val = s_ff.msk1;
			`FSC_IDX_SLOT: rd_val = s_ff.slot;
			`FSC_IDX_SLOTTM: rd_val = s_ff.slot_cnt;
			`FSC_IDX_IFS: rd_val = {s_ff.ifs_cnt, s_ff.ifs_first};
			`FSC_IDX_BACKOFF_COUNTDOWN: rd_val = s_ff.backoff_countdown;
			default: rd_val = 8'h00;
		endcase
		nxt_s.dat = (req && !wb_we_i) ? rd_val : 8'h00;

		// Decoded flags follow the new register value so they land with it
		nxt_s.marker = !nxt_s.mode[`FSC_MODE_PROTO];
		nxt_s.raw_tx = nxt_s.mode[`FSC_MODE_SEL_HI:`FSC_MODE_SEL_LO] == 2'b01;
		nxt_s.raw_rx = nxt_s.mode[`FSC_MODE_SEL_HI:`FSC_MODE_SEL_LO] == 2'b10;
		nxt_s.alt = nxt_s.mode[`FSC_MODE_SEL_HI:`FSC_MODE_SEL_LO] == 2'b11;
		nxt_s.fill = nxt_s.pctl[`FSC_PCTL_FILL] && nxt_s.mode[`FSC_MODE_PROTO];

		if (rst_i) begin
			nxt_s = '0;
			nxt_s.mode = `FSC_RST_BYTE;
			nxt_s.baud_rld = `FSC_RST_BYTE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i) begin
		s_ff <= nxt_s;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, each from a flop or a decoded flopped field
	assign wb_ack_o = s_ff.ack;
	assign wb_dat_o = {24'h00_0000, s_ff.dat};
	assign tx_pin_o = s_ff.tx_pin;
	assign rx_data_o = s_ff.rx_data;
	assign addr_hit_o = s_ff.hit;
	assign tx_bit_o = s_ff.tx_bit;
	assign rx_bit_o = s_ff.rx_bit;
	assign slot_tick_o = s_ff.slot_tick;
	assign ifs_busy_o = s_ff.ifs_run;
	assign backoff_busy_o = s_ff.bk_run;
	assign rx_stop_o = s_ff.rx_stop;
	assign rx_end_o = s_ff.rx_end;
	assign sdlc_o = s_ff.mode[`FSC_MODE_PROTO];
	assign crc32_o = s_ff.mode[`FSC_MODE_CRC];
	assign preamble_bits_o = s_ff.pre_bits;
	// Start marker of two ones counts inside the CSMA/CD preamble
	assign start_marker_ones_o = s_ff.marker;
	assign raw_tx_o = s_ff.raw_tx;
	assign raw_rx_o = s_ff.raw_rx;
	assign alt_backoff_o = s_ff.alt;
	assign det_res_o = s_ff.slot[`FSC_SLOT_DCR];
	assign dc_jam_o = s_ff.slot[`FSC_SLOT_DCJ];
	assign idle_fill_o = s_ff.fill;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	a_all_ones_hit: assert property (rx_addr_valid_i && rx_addr_i == 16'hFFFF |=> addr_hit_o)
		else $error("all-ones address missed");
	a_backoff_countdown_ro: assert property (wr && idx == `FSC_IDX_BACKOFF_COUNTDOWN && !collision_i
		&& !(s_ff.bk_run && slot_evt) && !(s_ff.bk_pend && ifs_done)
		|=> $stable(s_ff.backoff_countdown))
		else $error("backoff changed by write");
	a_baud_reload: assert property (s_ff.pre == 3'h7 && s_ff.baud_cnt == 8'h00
		&& !wr |=> s_ff.baud_cnt == $past(s_ff.baud_rld))
		else $error("divisor not reloaded");
	a_gen_period: assert property (gen_tick |=> !gen_tick [*7])
		else $error("bit tick too close");
	a_alt_hold: assert property (s_ff.bk_pend && !collision_i |-> !s_ff.bk_run)
		else $error("backoff ran before space end");
	a_no_retrigger: assert property (deterministic_resolution && carrier_i && !ifs_start_i && s_ff.ifs_run
		&& !tx_tick |=> s_ff.ifs_cnt == $past(s_ff.ifs_cnt))
		else $error("carrier retriggered space");
	a_b2b_keep: assert property (end_flag_i && sdlc && s_ff.pctl[`FSC_PCTL_B2B]
		|=> rx_end_o && !rx_stop_o)
		else $error("end flag stopped receiver");
	a_slot_zero: assert property (collision_i && deterministic_resolution && s_ff.slot[5:0] == 6'h00
		|=> s_ff.backoff_countdown == 8'h40)
		else $error("slot zero wait wrong");
	a_idle_fill: assert property (!sdlc_o |-> !idle_fill_o)
		else $error("idle fill outside SDLC");
endmodule

// >>> verification/fsc_far_station.sv
`timescale 1ns/1ps
// Far station: its bit clocks run only inside a frame, line rests high
module fsc_far_station (
	// Frame request
	input wire logic go_i,
	input wire logic [7:0] bits_i,
	// Toward the channel
	output logic tclk_o,
	output logic rclk_o,
	output logic line_o
);
	// Offset from the core clock so every edge lands 12 ns after a rising core clock edge
	initial begin
		tclk_o = 1'b0;
		rclk_o = 1'b0;
		line_o = 1'b1;
		forever begin
			@(posedge go_i);
			#37;
			repeat (bits_i) begin
				line_o = ~line_o;
				#100;
				tclk_o = 1'b1;
				rclk_o = 1'b1;
				#100;
				tclk_o = 1'b0;
				rclk_o = 1'b0;
			end
			line_o = 1'b1;
		end
	end
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	// Bus and clock
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [9:0] wb_adr_i;
	logic [3:0] wb_sel_i, wsel;
	logic [31:0] wb_dat_i, wb_dat_o;
	// Line and framer side
	logic ext_tx_clk_i, ext_rx_clk_i, rx_pin_i, tx_pin_o, tx_data_i, td_d, av_d, go;
	logic rx_addr_valid_i, collision_i, ifs_start_i, carrier_i, end_flag_i;
	logic [15:0] rx_addr_i;
	logic [7:0] backoff_seed_i;
	logic rx_data_o, addr_hit_o, tx_bit_o, rx_bit_o, slot_tick_o, ifs_busy_o, backoff_busy_o;
	logic rx_stop_o, rx_end_o, sdlc_o, crc32_o, start_marker_ones_o, raw_tx_o, raw_rx_o;
	logic alt_backoff_o, det_res_o, dc_jam_o, idle_fill_o;
	logic [6:0] preamble_bits_o;
	// Bookkeeping
	int n_errors = 0, num_checks = 0, cycles = 0, ntx = 0, nrx = 0, n, n1;
	integer seed = 32'ha707;
	logic [31:0] rdq[$];
	logic hitq[$];
	logic [7:0] r[6], v;
	logic [15:0] a;
	logic [7:0] ids[12] = '{8'h84, 8'h87, 8'h94, 8'h95, 8'ha4, 8'ha5, 8'hb5, 8'hc4, 8'hc5,
		8'hd5, 8'he5, 8'hf5};
	logic [7:0] aid[6] = '{8'h95, 8'ha5, 8'hb5, 8'hc5, 8'hd5, 8'he5};
	logic [6:0] pre[4] = '{7'h00, 7'h08, 7'h20, 7'h40};

	fsc_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_tx_clk_i(ext_tx_clk_i),
		.ext_rx_clk_i(ext_rx_clk_i), .rx_pin_i(rx_pin_i), .tx_pin_o(tx_pin_o),
		.tx_data_i(tx_data_i), .rx_addr_i(rx_addr_i), .rx_addr_valid_i(rx_addr_valid_i),
		.collision_i(collision_i), .backoff_seed_i(backoff_seed_i), .ifs_start_i(ifs_start_i),
		.carrier_i(carrier_i), .end_flag_i(end_flag_i), .rx_data_o(rx_data_o),
		.addr_hit_o(addr_hit_o), .tx_bit_o(tx_bit_o), .rx_bit_o(rx_bit_o),
		.slot_tick_o(slot_tick_o), .ifs_busy_o(ifs_busy_o), .backoff_busy_o(backoff_busy_o),
		.rx_stop_o(rx_stop_o), .rx_end_o(rx_end_o), .sdlc_o(sdlc_o), .crc32_o(crc32_o),
		.preamble_bits_o(preamble_bits_o), .start_marker_ones_o(start_marker_ones_o),
		.raw_tx_o(raw_tx_o), .raw_rx_o(raw_rx_o), .alt_backoff_o(alt_backoff_o),
		.det_res_o(det_res_o), .dc_jam_o(dc_jam_o), .idle_fill_o(idle_fill_o));
	fsc_far_station far (.go_i(go), .bits_i(8'h08), .tclk_o(ext_tx_clk_i),
		.rclk_o(ext_rx_clk_i), .line_o(rx_pin_i));

	////////////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Random framer bits, tick tallies and the hang limit
	always @(posedge clk_i) begin
		tx_data_i <= 1'($random(seed));
		td_d <= tx_data_i;
		av_d <= rx_addr_valid_i;
		cycles <= cycles + 1;
		if (tx_bit_o === 1'b1) ntx <= ntx + 1;
		if (rx_bit_o === 1'b1) nrx <= nrx + 1;
		if (cycles == 5000) begin
			n_errors++;
			conclude();
		end
	end

	// Watcher: oldest note against each read answer and address verdict
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk(wb_dat_o, rdq.pop_front());
		if (av_d === 1'b1) chk(addr_hit_o, hitq.pop_front());
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One classic cycle; it holds everything until ack is sampled
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		input logic [7:0] e);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= wsel;
		wb_dat_i <= {24'($random(seed)), d};
		if (!w) rdq.push_back({24'h0, e});
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wait_tick(output int k);
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (tx_bit_o !== 1'b1 && k < 4000);
	endtask

	// Pulses one framer strobe for one cycle
	task automatic pulse(input int which);
		collision_i <= (which == 0);
		ifs_start_i <= (which == 1);
		end_flag_i <= (which == 2);
		@(posedge clk_i);
		{collision_i, ifs_start_i, end_flag_i} <= 3'b000;
	endtask

	function automatic logic hit_exp(input logic [15:0] x, input logic wide);
		if (wide)
			return ((x | {r[5], r[4]}) == ({r[1], r[0]} | {r[5], r[4]})) || x == {r[3], r[2]} || &x;
		return ((x[7:0] | r[4]) == (r[0] | r[4])) || ((x[7:0] | r[5]) == (r[1] | r[5]))
			|| x[7:0] == r[2] || x[7:0] == r[3] || &x[7:0];
	endfunction

	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst_i, wsel, go} = 6'h3e;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		{tx_data_i, rx_addr_i, rx_addr_valid_i, backoff_seed_i, av_d} = '0;
		{collision_i, ifs_start_i, carrier_i, end_flag_i} = 4'h0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ids[i]) wb(0, ids[i], 8'h00, 8'h00);
		// Divisor 3 gives a tick every 32 clocks, then slow ticks so timers hold still
		wb(1, 8'h94, 8'h03, 0);
		repeat (3) wait_tick(n);
		chk(n, 32);
		wb(1, 8'h94, 8'hff, 0);
		// Match values and sparse masks; a write with lane 0 off stores nothing
		for (int i = 0; i < 6; i++) begin
			r[i] = (i > 3) ? (8'h0f & 8'($random(seed))) : 8'($random(seed));
			wb(1, aid[i], r[i], 0);
			wb(0, aid[i], 0, r[i]);
		end
		wsel = 4'he;
		wb(1, 8'h95, ~r[0], 0);
		wsel = 4'h1;
		wb(0, 8'h95, 0, r[0]);
		wb(1, 8'hc4, 8'h55, 0);
		wb(0, 8'hc4, 0, 0);
		wb(1, 8'h10, 8'ha5, 0);
		wb(0, 8'h10, 0, 0);
		// Back-to-back addresses: random, pair hits, masked hits, all ones
		for (int m = 0; m < 2; m++) begin
			wb(1, 8'h84, {3'b0, m[0], 4'h0}, 0);
			for (int k = 0; k < 48; k++) begin
				a = 16'($random(seed));
				case (k % 4)
					1: a = {r[3], r[2]};
					2: a = {r[1], r[0]} ^ ({r[5], r[4]} & a);
					3: a = a | (m ? 16'hffff : 16'h00ff);
					default: ;
				endcase
				rx_addr_i <= a;
				rx_addr_valid_i <= 1'b1;
				hitq.push_back(hit_exp(a, m[0]));
				@(posedge clk_i);
			end
			rx_addr_valid_i <= 1'b0;
		end
		// Only bits 4..2 of the control register are kept
		wb(1, 8'h87, 8'hff, 0);
		wb(0, 8'h87, 0, 8'h1c);
		wb(1, 8'h87, 8'h14, 0);
		for (int i = 0; i < 16; i++) begin
			v = {1'b0, i[1:0], 2'($random(seed)), i[3:2], i[0] ^ i[3]};
			wb(1, 8'h84, v, 0);
			@(posedge clk_i);
			@(negedge clk_i);
			chk(sdlc_o, v[0]);
			chk(start_marker_ones_o, !v[0]);
			chk(crc32_o, v[3]);
			chk(preamble_bits_o, pre[v[2:1]]);
			chk(raw_tx_o, v[6:5] == 2'b01);
			chk(raw_rx_o, v[6:5] == 2'b10);
			chk(alt_backoff_o, v[6:5] == 2'b11);
			chk(tx_pin_o, (v[6:5] == 2'b01) | td_d);
			chk(idle_fill_o, v[0]);
			chk(rx_data_o, (v[6:5] == 2'b01) ? td_d : 1'b1);
			wb(0, 8'h84, 0, v);
		end
		for (int j = 0; j < 4; j++) begin
			wb(1, 8'hf5, {j[1:0], 6'h2a}, 0);
			@(negedge clk_i);
			chk(dc_jam_o, j[1]);
			chk(det_res_o, j[0]);
		end
		// Deterministic slots in alternate mode, then slot zero waits all 64
		wb(1, 8'h84, 8'h60, 0);
		pulse(0);
		wb(0, 8'hc4, 0, 8'd21);
		wb(1, 8'hf5, 8'h40, 0);
		pulse(0);
		wb(0, 8'hc4, 0, 8'h40);
		// Random backoff load with resolution off
		wb(1, 8'hf5, 8'h00, 0);
		wb(1, 8'h84, 8'h00, 0);
		backoff_seed_i <= 8'h01 | 8'($random(seed));
		pulse(0);
		wb(0, 8'hc4, 0, backoff_seed_i);
		chk(backoff_busy_o, 1'b1);
		// Interframe space: half stored, first pass flagged
		wb(1, 8'ha4, 8'h10, 0);
		pulse(1);
		wb(0, 8'ha4, 0, 8'h11);
		chk(ifs_busy_o, 1'b1);
		// Alternate mode with the space still running holds a fresh backoff
		wb(1, 8'h84, 8'h60, 0);
		pulse(0);
		@(negedge clk_i);
		chk(backoff_busy_o, 1'b0);
		wb(0, 8'hc4, 0, backoff_seed_i);
		// End flag stops the receiver unless SDLC with back-to-back set
		for (int i = 0; i < 2; i++) begin
			wb(1, 8'h84, {7'h0, i[0]}, 0);
			pulse(2);
			@(negedge clk_i);
			chk(rx_end_o, 1'b1);
			chk(rx_stop_o, !i[0]);
		end
		// External clocks: one 8-bit frame gives eight ticks each way
		wb(1, 8'h84, 8'h80, 0);
		wb(1, 8'h87, 8'h08, 0);
		n = ntx;
		n1 = nrx;
		go <= 1'b1;
		repeat (120) @(posedge clk_i);
		go <= 1'b0;
		chk(ntx - n, 8);
		chk(nrx - n1, 8);
		chk(rdq.size() + hitq.size(), 0);
		conclude();
	end
endmodule
